// ===== verif/hdu9_monitor.sv
// port checker for the 9-bit uart
`timescale 1ns/1ns
module hdu9_monitor (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    // serial and interrupt
    input wire rx_pin,
    input wire port_value,
    input wire tx_pin,
    input wire tx_output_select,
    input wire irq
);
    reg [15:0] busy_cnt;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            busy_cnt <= 16'h0000;
        else
            busy_cnt <= tx_output_select ? busy_cnt + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_data_wr_start: assert property (wr && addr == 8'hd6 |=> tx_output_select && !tx_pin)
        else $error("no start bit after data write");
    a_start_bit_low: assert property ($rose(tx_output_select) |-> !tx_pin [*8])
        else $error("start bit too short");
    // 208 clocks a bit is the fastest rate, so no frame may end sooner
    a_frame_length: assert property ($fell(tx_output_select) |-> busy_cnt >= 16'h08e8)
        else $error("frame ended early");
    a_pin_follow: assert property (!tx_output_select && !$past(tx_output_select) |-> tx_pin == $past(port_value))
        else $error("pin not following port");
    a_unmapped_zero: assert property (rd && addr != 8'hd6 && addr != 8'hd7 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data without read");
    a_irq_masked: assert property (wr && addr == 8'hd7 && wdata[5:4] == 2'b00 |=> ##1 !irq)
        else $error("irq with both enables off");
    a_reset_state: assert property (@(posedge clk) disable iff (1'b0)
        !arst_n |-> tx_pin && !tx_output_select && !irq && rdata == 8'h00)
        else $error("outputs not idle in reset");
endmodule // hdu9_monitor

// ===== verif/hdu9_remote.sv
// remote serial node: sends frames to the receive line, captures frames from the transmit line
`timescale 1ns/1ns
module hdu9_remote (
    // clock
    input wire clk,
    // serial lines
    output reg line_out,
    input wire line_in
);
    initial line_out = 1'b1;
    task send(input [8:0] v, input integer div);
        reg [10:0] f;
        integer i;
        begin
            f = {1'b1, v, 1'b0};
            for (i = 0; i < 11; i = i + 1) begin
                line_out <= f[i];
                repeat (div) @(posedge clk);
            end
        end
    endtask
    // mid-bit sampling leaves half a bit of slack for a late start
    task recv(input integer div, output [8:0] v);
        integer k;
        begin
            k = 0;
            while (line_in && k < 100) begin
                @(posedge clk);
                k = k + 1;
            end
            repeat (div / 2) @(posedge clk);
            for (k = 0; k < 9; k = k + 1) begin
                repeat (div) @(posedge clk);
                v[k] = line_in;
            end
        end
    endtask
endmodule // hdu9_remote

// ===== verif/tb.sv
// self-checking bench for the 9-bit uart
`timescale 1ns/1ns
module tb;
    reg clk;
    reg arst_n;
    reg [7:0] addr;
    reg [7:0] wdata;
    reg wr;
    reg rd;
    reg port_value;
    wire [7:0] rdata;
    wire rx_pin;
    wire tx_pin;
    wire tx_output_select;
    wire irq;
    integer bad_count;
    integer n_tests;
    integer t;
    integer k;
    integer d;
    integer s;
    reg [7:0] r;
    reg [8:0] v;
    hdu9_uart u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rx_pin(rx_pin), .port_value(port_value), .tx_pin(tx_pin), .tx_output_select(tx_output_select), .irq(irq));
    hdu9_remote u_remote (.clk(clk), .line_out(rx_pin), .line_in(tx_pin));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task check(input [8:0] seen, input [8:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] dat);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= dat;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(negedge clk);
            r = rdata;
        end
    endtask
    task wait_tx;
        begin
            t = 0;
            #1;
            while (tx_output_select !== 1'b0 && t < 80000) begin
                @(posedge clk);
                #1;
                t = t + 1;
            end
            if (t >= 80000)
                bad_count = bad_count + 1;
        end
    endtask
    // reset in mid-frame: outputs go idle at once and the port answers right after release
    task t_mid_reset;
        begin
            @(posedge clk);
            arst_n <= 1'b0;
            repeat (2) @(negedge clk);
            check({6'h00, irq, tx_output_select, tx_pin}, 9'h001);
            @(posedge clk);
            arst_n <= 1'b1;
            rd_reg(8'hd7);
            check({1'b0, r}, 9'h000);
            check({6'h00, irq, tx_output_select, tx_pin}, 9'h001);
        end
    endtask
    task t_reset;
        begin
            rd_reg(8'hd7);
            check({1'b0, r}, 9'h000);
            rd_reg(8'h55);
            check({1'b0, r}, 9'h000);
            @(posedge clk);
            port_value <= 1'b0;
            repeat (2) @(negedge clk);
            check({8'h00, tx_pin}, 9'h000);
            @(posedge clk);
            port_value <= 1'b1;
            $display("test reset done");
        end
    endtask
    task t_tx;
        begin
            wr_reg(8'hd7, 8'h1d);
            wr_reg(8'hd6, 8'ha5);
            u_remote.recv(208, v);
            check(v, 9'h1a5);
            wait_tx;
            repeat (2) @(negedge clk);
            check({8'h00, irq}, 9'h001);
            rd_reg(8'hd7);
            check({1'b0, r}, 9'h05d);
            wr_reg(8'hd7, 8'h1d);
            rd_reg(8'hd7);
            check({1'b0, r}, 9'h01d);
            check({8'h00, irq}, 9'h000);
            $display("test tx done");
        end
    endtask
    task t_rx;
        begin
            wr_reg(8'hd7, 8'h2d);
            u_remote.send(9'h03c, 208);
            t = 0;
            while (irq !== 1'b1 && t < 500) begin
                @(negedge clk);
                t = t + 1;
            end
            check({8'h00, irq}, 9'h001);
            rd_reg(8'hd6);
            check({1'b0, r}, 9'h03c);
            rd_reg(8'hd7);
            check({1'b0, r}, 9'h0ac);
            $display("test rx done");
        end
    endtask
    task t_abort;
        begin
            wr_reg(8'hd7, 8'h0c);
            fork
                u_remote.send(9'h181, 208);
                begin
                    repeat (600) @(posedge clk);
                    wr_reg(8'hd6, 8'h77);
                end
            join
            wait_tx;
            repeat (300) @(posedge clk);
            rd_reg(8'hd7);
            check({1'b0, r}, 9'h04c);
            $display("test abort done");
        end
    endtask
    task t_sw_irq;
        begin
            wr_reg(8'hd7, 8'ha0);
            repeat (2) @(negedge clk);
            check({8'h00, irq}, 9'h001);
            wr_reg(8'hd7, 8'h20);
            repeat (2) @(negedge clk);
            check({8'h00, irq}, 9'h000);
            $display("test sw irq done");
        end
    endtask
    // slow codes 000..010 are timed on the start bit only and cut short by a reset to keep the run short
    task t_baud;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                d = (k == 5) ? 256 : (k > 5) ? 208 : (6656 >> k);
                wr_reg(8'hd7, {4'h0, k[2:0], 1'b0});
                wr_reg(8'hd6, 8'h01);
                t = 0;
                #1;
                while (tx_pin !== 1'b1 && t < 8000) begin
                    @(posedge clk);
                    #1;
                    t = t + 1;
                end
                s = t;
                check({8'h00, s >= d - d / 8 && s <= d + 8}, 9'h001);
                if (k < 3) begin
                    t_mid_reset;
                end else begin
                    wait_tx;
                    check({8'h00, s + t >= 11 * d - d / 8 && s + t <= 11 * d + 8}, 9'h001);
                end
            end
            $display("test baud done");
        end
    endtask
    task results;
        begin
            $display("compares %0d mismatches %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        bad_count = 0;
        n_tests = 0;
        arst_n = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        port_value = 1'b1;
        // reset falls off the edge so the asynchronous clear lands before the first clock
        #2;
        arst_n = 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_tx;
        t_rx;
        t_abort;
        t_sw_irq;
        t_baud;
        results;
    end
    initial begin
        #480000;
        bad_count = bad_count + 1;
        results;
    end
endmodule // tb
bind hdu9_uart hdu9_monitor u_mon (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_pin(rx_pin), .port_value(port_value), .tx_pin(tx_pin), .tx_output_select(tx_output_select),
    .irq(irq));

// ===== verilog/hdu9_defines.vh
// register map, field positions, reset values and baud divisors of the 9-bit uart
`ifndef HDU9_DEFINES_VH
`define HDU9_DEFINES_VH
`define HDU9_ADDR_DATA 8'hd6
`define HDU9_ADDR_CTRL 8'hd7
`define HDU9_BIT_RX_CHAR_READY_FLAG 7
`define HDU9_BIT_TXDONE 6
`define HDU9_BIT_RX_IRQ_ENABLE 5
`define HDU9_BIT_TX_IRQ_ENABLE 4
`define HDU9_BIT_BAUD_HI 3
`define HDU9_BIT_BAUD_LO 1
`define HDU9_BIT_NINTH 0
`define HDU9_CTRL_RESET 8'h00
`define HDU9_OVERSAMPLE 4'h8
`define HDU9_DIV_000 16'h1a00
`define HDU9_DIV_001 16'h0d00
`define HDU9_DIV_010 16'h0680
`define HDU9_DIV_011 16'h0340
`define HDU9_DIV_100 16'h01a0
`define HDU9_DIV_101 16'h0100
`define HDU9_DIV_110 16'h00d0
`define HDU9_SAMPLE_A 3'h3
`define HDU9_SAMPLE_B 3'h4
`define HDU9_SAMPLE_C 3'h5
`endif

// ===== verilog/hdu9_tick_gen.v
// oversampling tick generator: one pulse every divisor/8 internal clocks
`timescale 1ns/1ns
`include "hdu9_defines.vh"
module hdu9_tick_gen (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // control
    input wire [2:0] baud_select,
    input wire restart,
    // output
    output reg tick
);
    reg [12:0] count;
    reg [12:0] reload;

    function [12:0] hdu9_div8;
        input [2:0] sel;
        reg [15:0] d;
        begin
            case (sel)
                3'h0: d = `HDU9_DIV_000;
                3'h1: d = `HDU9_DIV_001;
                3'h2: d = `HDU9_DIV_010;
                3'h3: d = `HDU9_DIV_011;
                3'h4: d = `HDU9_DIV_100;
                3'h5: d = `HDU9_DIV_101;
                3'h6: d = `HDU9_DIV_110;
                // reserved code runs at the fastest rate rather than stalling
                default: d = `HDU9_DIV_110;
            endcase
            hdu9_div8 = d[15:3] - 13'h0001;
        end
    endfunction

    always @* begin
        reload = hdu9_div8(baud_select);
    end

    // new selection takes effect at the next reload, no resync
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 13'h0000;
            tick <= 1'b0;
        end else if (restart) begin
            count <= reload;
            tick <= 1'b0;
        end else if (count == 13'h0000) begin
            count <= reload;
            tick <= 1'b1;
        end else begin
            count <= count - 13'h0001;
            tick <= 1'b0;
        end
    end
endmodule // hdu9_tick_gen

// ===== verilog/hdu9_uart.v
// half-duplex 9-bit uart with register port and level interrupt
// Functional notes
// - receiver watches falling edge unless transmitting
// - start bit spans eight oversample states
// - received ninth bit overwrites control ninth bit
// - wait stop bit, then load receive buffer
// - ready flag set on buffer load, interrupts
// - transmit start aborts ongoing reception
// - each interrupt source gated by own enable
// - data write loads shifter, starts, clears empty
// - data read returns receive buffer
// - baud select picks fixed divisor
// - baud change applies at next reload
// - ready flag written zero clears, one sets
// - empty flag set after send, zero clears
// - enable writes also load both flags
// - ninth bit write sets transmit level
// - eight ticks per bit, majority of three
// - frame: start, eight lsb-first, ninth, stop
// - tx pin follows port unless sending
`timescale 1ns/1ns
`include "hdu9_defines.vh"
module hdu9_uart (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    // serial lines
    input wire rx_pin,
    input wire port_value,
    output reg tx_pin,
    output reg tx_output_select,
    // interrupt
    output reg irq
);
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_STOP = 2'h3;

    // control register fields and receive buffer
    reg rx_char_ready_flag;
    reg tx_done_flag;
    reg rx_irq_enable;
    reg tx_irq_enable;
    reg [2:0] baud_select;
    reg ninth_data_bit;
    reg [7:0] serial_data_buffer;

    // rx synchroniser and history
    reg rx_meta;
    reg rx_sync;
    reg rx_prev;

    // transmitter
    reg tx_busy;
    reg [1:0] tx_state;
    reg [3:0] tx_phase;
    reg [3:0] tx_bit;
    reg [8:0] tx_shift;

    // receiver
    reg [1:0] rx_state;
    reg [2:0] rx_phase;
    reg [3:0] rx_bit;
    reg [8:0] rx_shift;
    reg [1:0] vote;

    wire wr_data = wr && (addr == `HDU9_ADDR_DATA);
    wire wr_ctrl = wr && (addr == `HDU9_ADDR_CTRL);
    wire rd_data = rd && (addr == `HDU9_ADDR_DATA);
    wire rd_ctrl = rd && (addr == `HDU9_ADDR_CTRL);

    wire tick;
    // the divider restarts on each frame so the first state has a full length
    wire rx_edge = rx_prev && !rx_sync && !tx_busy && (rx_state == ST_IDLE);
    hdu9_tick_gen u_tick (
        .clk(clk),
        .arst_n(arst_n),
        .baud_select(baud_select),
        .restart(wr_data || rx_edge),
        .tick(tick)
    );

    wire rx_done = tick && (rx_state == ST_STOP) && (rx_phase == 3'h7) && !tx_busy && !wr_data;
    wire tx_finish = tick && tx_busy && (tx_state == ST_STOP) && (tx_phase == 4'h7);
    wire next_ninth = vote[1] | (vote[0] & rx_sync);
    wire [7:0] ctrl_view = {rx_char_ready_flag, tx_done_flag, rx_irq_enable, tx_irq_enable,
                            baud_select, ninth_data_bit};

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // register writes and hardware flag updates; hardware sets win over clears
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {rx_char_ready_flag, tx_done_flag, rx_irq_enable, tx_irq_enable} <= 4'h0;
            baud_select <= 3'h0;
            ninth_data_bit <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                rx_char_ready_flag <= wdata[`HDU9_BIT_RX_CHAR_READY_FLAG];
                tx_done_flag <= wdata[`HDU9_BIT_TXDONE];
                rx_irq_enable <= wdata[`HDU9_BIT_RX_IRQ_ENABLE];
                tx_irq_enable <= wdata[`HDU9_BIT_TX_IRQ_ENABLE];
                baud_select <= wdata[`HDU9_BIT_BAUD_HI:`HDU9_BIT_BAUD_LO];
                ninth_data_bit <= wdata[`HDU9_BIT_NINTH];
            end
            if (wr_data)
                tx_done_flag <= 1'b0;
            if (tx_finish)
                tx_done_flag <= 1'b1;
            if (rx_done) begin
                rx_char_ready_flag <= 1'b1;
                ninth_data_bit <= rx_shift[8];
            end
        end
    end

    // transmitter: start, 8 data lsb first, ninth, stop
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_busy <= 1'b0;
            tx_state <= ST_IDLE;
            tx_phase <= 4'h0;
            tx_bit <= 4'h0;
            tx_shift <= 9'h000;
            tx_pin <= 1'b1;
            tx_output_select <= 1'b0;
        end else begin
            if (wr_data) begin
                // ninth bit taken from the control value as it stands now
                tx_shift <= {ninth_data_bit, wdata};
                tx_busy <= 1'b1;
                tx_state <= ST_START;
                tx_phase <= 4'h0;
                tx_bit <= 4'h0;
                tx_pin <= 1'b0;
                tx_output_select <= 1'b1;
            end else if (tick && tx_busy) begin
                if (tx_phase != 4'h7) begin
                    tx_phase <= tx_phase + 4'h1;
                end else begin
                    tx_phase <= 4'h0;
                    case (tx_state)
                        ST_START: begin
                            tx_state <= ST_DATA;
                            tx_pin <= tx_shift[0];
                        end
                        ST_DATA: begin
                            if (tx_bit == 4'h8) begin
                                tx_state <= ST_STOP;
                                tx_pin <= 1'b1;
                            end else begin
                                tx_bit <= tx_bit + 4'h1;
                                tx_shift <= {1'b0, tx_shift[8:1]};
                                tx_pin <= tx_shift[1];
                            end
                        end
                        ST_STOP: begin
                            tx_busy <= 1'b0;
                            tx_state <= ST_IDLE;
                            tx_output_select <= 1'b0;
                            tx_pin <= port_value;
                        end
                        default: tx_state <= ST_IDLE;
                    endcase
                end
            end else if (!tx_busy) begin
                // port value is same-domain logic, passed straight through
                tx_pin <= port_value;
            end
        end
    end

    // receiver with 3-sample majority vote
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_state <= ST_IDLE;
            rx_phase <= 3'h0;
            rx_bit <= 4'h0;
            rx_shift <= 9'h000;
            vote <= 2'h0;
            serial_data_buffer <= 8'h00;
        end else if (tx_busy || wr_data) begin
            rx_state <= ST_IDLE;
            rx_phase <= 3'h0;
        end else if (rx_edge) begin
            rx_state <= ST_START;
            rx_phase <= 3'h0;
            rx_bit <= 4'h0;
            vote <= 2'h0;
        end else if (tick && rx_state != ST_IDLE) begin
            rx_phase <= rx_phase + 3'h1;
            if (rx_phase == `HDU9_SAMPLE_A)
                vote <= {1'b0, rx_sync};
            else if (rx_phase == `HDU9_SAMPLE_B)
                vote <= {vote[0] & rx_sync, vote[0] | rx_sync};
            else if (rx_phase == `HDU9_SAMPLE_C && rx_state == ST_DATA)
                rx_shift <= {next_ninth, rx_shift[8:1]};
            if (rx_phase == 3'h7) begin
                case (rx_state)
                    ST_START: rx_state <= ST_DATA;
                    ST_DATA: begin
                        if (rx_bit == 4'h8)
                            rx_state <= ST_STOP;
                        else
                            rx_bit <= rx_bit + 4'h1;
                    end
                    ST_STOP: begin
                        serial_data_buffer <= rx_shift[7:0];
                        rx_state <= ST_IDLE;
                    end
                    default: rx_state <= ST_IDLE;
                endcase
            end
        end
    end

    // read data valid the cycle after the strobe; unmapped reads give zero
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (rd_data) begin
            rdata <= serial_data_buffer;
        end else if (rd_ctrl) begin
            rdata <= ctrl_view;
        end else begin
            rdata <= 8'h00;
        end
    end

    // level interrupt; flags are cleared by software write only
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= (rx_char_ready_flag & rx_irq_enable) | (tx_done_flag & tx_irq_enable);
    end
endmodule // hdu9_uart
